// file: core/shs_pkg.sv
// Package for the spindle and head supervisor: timing figures, thresholds,
// the commutation table and the carrier structs.
// Assumes a single 10 MHz core clock; all other clocks arrive as sampled levels.
package shs_pkg;

  // Core clock
  localparam int unsigned CLK_HZ = 10_000_000;

  // Spindle nominal speed and the start-up window, in percent
  localparam int unsigned NOMINAL_RPM = 3600;
  localparam int unsigned START_TOL_PCT = 1;

  // Index period in core cycles; least time rounds up, longest rounds down
  localparam int unsigned IDX_NOM_CYC = CLK_HZ * 60 / NOMINAL_RPM;
  localparam int unsigned IDX_MIN_CYC =
    (IDX_NOM_CYC * (100 - START_TOL_PCT) + 99) / 100;
  localparam int unsigned IDX_MAX_CYC = IDX_NOM_CYC * (100 + START_TOL_PCT) / 100;
  localparam int unsigned IDX_CNT_W = 18;

  // Speed checker reference and its tick window per revolution
  localparam int unsigned CHK_REF_HZ = 92_100;
  localparam int unsigned CHK_NOM_TICKS = CHK_REF_HZ * 60 / NOMINAL_RPM;
  localparam int unsigned CHK_TOL_PCT = 1;
  localparam int unsigned CHK_CNT_W = 12;
  localparam logic [CHK_CNT_W-1:0] CHK_MIN_TICKS =
    CHK_CNT_W'((CHK_NOM_TICKS * (100 - CHK_TOL_PCT) + 99) / 100);
  localparam logic [CHK_CNT_W-1:0] CHK_MAX_TICKS =
    CHK_CNT_W'(CHK_NOM_TICKS * (100 + CHK_TOL_PCT) / 100);
  localparam logic [CHK_CNT_W-1:0] CHK_SAT = 12'hFFF;

  // Regulator phase error range (reference edges minus Hall edges)
  localparam int unsigned REF_REG_HZ = 360;
  localparam logic signed [3:0] PHASE_MAX = 4'sh7;
  localparam logic signed [3:0] PHASE_MIN = -4'sh7;

  // Synchroniser width: three Hall bits, index, unsafe
  localparam int unsigned SYNC_W = 5;

  // Hall state to phase drive, one-hot or idle for illegal codes
  localparam logic [2:0] COMM_TABLE [8] = '{
    3'h0, 3'h1, 3'h2, 3'h2, 3'h4, 3'h1, 3'h4, 3'h0
  };

  // Reset levels of the supervisor outputs
  localparam logic RST_CHIP_EN_N = 1'b1;
  localparam logic RST_INDEX_N = 1'b1;

  typedef enum logic [1:0] {
    ST_ACCEL,
    ST_REGULATE,
    ST_RUN,
    ST_STOP
  } shs_state_t;

  typedef struct packed {
    logic chipEnableN;
    logic writeSelect;
    logic headCodeBitHigh;
    logic headCodeBitLow;
  } shs_preamp_t;

  typedef struct packed {
    logic [2:0] phaseDrive;
    logic stopMotor;
    logic brakeRelay;
    logic normalRegulation;
    logic lockRelease;
  } shs_motor_t;

endpackage

// file: core/shs_sync2.sv
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes the consumer reads only dataOut; the first stage is private.
`timescale 1ns/1ps
`default_nettype none
module shs_sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] dataIn,
  output logic [W-1:0] dataOut
);

  logic [W-1:0] stage1;

  // First stage feeds only the second, to let metastability settle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      dataOut <= '0;
    end else begin
      stage1 <= dataIn;
      dataOut <= stage1;
    end
  end

endmodule
`default_nettype wire

// file: core/shs_supervisor.sv
// Spindle start-up, speed checking, commutation and head select for the
// head-disc module. Outputs are registered.
// Assumes the 92.1 kHz and 360 Hz references are synchronous to core_clk;
// Hall, index and unsafe pins are asynchronous and synchronised here.
// Notes on behaviour
// - Preamplifier works only while its active-low chip enable is asserted.
// - Two-bit binary head code selects one of four heads.
// - Write select high means write mode, low means read mode.
// - Unsafe from the preamplifier during writing becomes a write fault.
// - Unsafe in read mode, from stray write current, is a write fault too.
// - Index pulse used internally and buffered out active low.
// - Lock release asserted only after at-speed is true.
// - After reset, stop motor false and regulation off: free acceleration.
// - Index interval within one percent of 3600 rpm turns regulation on.
// - Stop motor goes to both speed control and brake relay driver.
// - Speed checker counts 92.1 kHz ticks per index: at-speed, not-ready.
// - Out-of-range speed or not-ready while running shuts the drive down.
// - Regulator compares Hall phase with 360 Hz reference and corrects drive.
// - Lookup table maps Hall inputs to one of three phase outputs.
// - Stop motor engages brake relay and removes three-phase drive.
`timescale 1ns/1ps
`default_nettype none
module shs_supervisor import shs_pkg::*; #(
  parameter int unsigned IDX_MIN = IDX_MIN_CYC,
  parameter int unsigned IDX_MAX = IDX_MAX_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Motor sensors, asynchronous
  input wire logic [2:0] hallRaw,
  input wire logic indexRaw,
  // Reference clocks, sampled as levels
  input wire logic refCheck,
  input wire logic refRegulate,
  // Preamplifier fault line, asynchronous
  input wire logic unsafeFault,
  // Drive control from the interface side
  input wire logic driveSelect,
  input wire logic [1:0] headSelect,
  input wire logic writeRequest,
  input wire logic stopRequest,
  // Preamplifier control
  output shs_preamp_t preamp,
  // Motor, brake and lock control
  output shs_motor_t motor,
  // Status
  output logic indexPulseN,
  output logic writeFault,
  output logic atSpeed,
  output logic counterNotReady
);

  localparam logic [IDX_CNT_W-1:0] IDX_LO = IDX_CNT_W'(IDX_MIN);
  localparam logic [IDX_CNT_W-1:0] IDX_HI = IDX_CNT_W'(IDX_MAX);
  localparam logic [IDX_CNT_W-1:0] IDX_SAT = {IDX_CNT_W{1'b1}};

  logic [SYNC_W-1:0] syncOut;
  logic [2:0] hallSync;
  logic indexSync, unsafeSync, indexDly, refChkDly, refRegDly, hallDly;
  logic indexRise, refChkRise, refRegRise, hallRise;
  logic [IDX_CNT_W-1:0] idxCnt;
  logic idxSeen, chkSeen;
  logic [CHK_CNT_W-1:0] chkCnt;
  logic signed [3:0] phaseErr;
  shs_state_t state, next_state;
  wire idxInBand, chkInBand, speedBad, driveOn, runNext, writeNext;
  wire [2:0] commPhase;

  // Asynchronous inputs pass two stages first
  shs_sync2 #(.W(SYNC_W)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .dataIn({unsafeFault, indexRaw, hallRaw}),
    .dataOut(syncOut)
  );
  assign hallSync = syncOut[2:0];
  assign indexSync = syncOut[3];
  assign unsafeSync = syncOut[4];

  // Edge detection works on synchronised or synchronous levels only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      indexDly <= 1'b0;
      refChkDly <= 1'b0;
      refRegDly <= 1'b0;
      hallDly <= 1'b0;
    end else begin
      indexDly <= indexSync;
      refChkDly <= refCheck;
      refRegDly <= refRegulate;
      hallDly <= hallSync[0];
    end
  end
  assign indexRise = indexSync & ~indexDly;
  assign refChkRise = refCheck & ~refChkDly;
  assign refRegRise = refRegulate & ~refRegDly;
  assign hallRise = hallSync[0] & ~hallDly;

  // Index interval in core cycles; saturates if the spindle is stalled
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      idxCnt <= '0;
      idxSeen <= 1'b0;
    end else if (indexRise) begin
      idxCnt <= IDX_CNT_W'(1);
      idxSeen <= 1'b1;
    end else if (idxCnt != IDX_SAT) begin
      idxCnt <= idxCnt + IDX_CNT_W'(1);
    end
  end
  // First index only starts timing, so no false early window
  assign idxInBand = indexRise & idxSeen & (idxCnt >= IDX_LO) & (idxCnt <= IDX_HI);

  // Speed checker: reference ticks per revolution
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chkCnt <= '0;
      chkSeen <= 1'b0;
      atSpeed <= 1'b0;
      counterNotReady <= 1'b1;
    end else if (indexRise) begin
      chkCnt <= '0;
      chkSeen <= 1'b1;
      atSpeed <= chkSeen & chkInBand;
      counterNotReady <= ~chkSeen | (chkCnt == CHK_SAT);
    end else if (chkCnt == CHK_SAT) begin
      // No index for a long time: report at once rather than wait
      atSpeed <= 1'b0;
      counterNotReady <= 1'b1;
    end else if (refChkRise) begin
      chkCnt <= chkCnt + CHK_CNT_W'(1);
    end
  end
  assign chkInBand = (chkCnt >= CHK_MIN_TICKS) & (chkCnt <= CHK_MAX_TICKS);
  assign speedBad = ~atSpeed | counterNotReady;

  // Phase error: 360 Hz reference edges minus Hall edges, saturating
  always_ff @(posedge core_clk) begin
    if (!rst_n || !motor.normalRegulation) begin
      phaseErr <= '0;
    end else if (refRegRise && !hallRise && phaseErr != PHASE_MAX) begin
      phaseErr <= phaseErr + 4'sh1;
    end else if (hallRise && !refRegRise && phaseErr != PHASE_MIN) begin
      phaseErr <= phaseErr - 4'sh1;
    end
  end
  // Full drive while unregulated; regulated drive only when lagging or in step
  assign driveOn = ~motor.normalRegulation | (phaseErr >= 4'sh0);

  // Start-up and supervision sequence
  always_comb begin
    next_state = state;
    unique case (state)
      ST_ACCEL: begin
        if (stopRequest) begin
          next_state = ST_STOP;
        end else if (idxInBand) begin
          next_state = ST_REGULATE;
        end
      end
      ST_REGULATE: begin
        if (stopRequest) begin
          next_state = ST_STOP;
        end else if (atSpeed && !counterNotReady) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stopRequest || speedBad) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        next_state = ST_STOP; // Only reset restarts the spindle
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ST_ACCEL;
    end else begin
      state <= next_state;
    end
  end

  // Motor controls follow the next state, so they move with it
  assign commPhase = COMM_TABLE[hallSync];
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      motor <= '0;
    end else begin
      motor.stopMotor <= (next_state == ST_STOP);
      motor.brakeRelay <= (next_state == ST_STOP);
      motor.normalRegulation <= (next_state == ST_REGULATE) || (next_state == ST_RUN);
      motor.lockRelease <= (next_state == ST_RUN);
      motor.phaseDrive <= (next_state != ST_STOP && driveOn) ? commPhase : 3'h0;
    end
  end

  // Head select and fault forwarding
  assign runNext = driveSelect & (next_state == ST_RUN);
  assign writeNext = runNext & writeRequest & ~writeFault;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      preamp <= '{chipEnableN: RST_CHIP_EN_N, default: 1'b0};
      writeFault <= 1'b0;
      indexPulseN <= RST_INDEX_N;
    end else begin
      preamp.chipEnableN <= ~runNext;
      preamp.writeSelect <= writeNext;
      preamp.headCodeBitHigh <= headSelect[1];
      preamp.headCodeBitLow <= headSelect[0];
      // Any mode: read-mode unsafe means stray write current
      writeFault <= unsafeSync & ~preamp.chipEnableN;
      indexPulseN <= ~indexSync;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_running_bad;
    (state == ST_RUN) && speedBad;
  endsequence

  sequence s_band_hit;
    (state == ST_ACCEL) && !stopRequest && idxInBand;
  endsequence

  a_write_needs_ce: assert property (preamp.writeSelect |-> !preamp.chipEnableN)
    else $error("write select while preamplifier disabled");
  a_head_code_track: assert property ($stable(headSelect) |=>
      {preamp.headCodeBitHigh, preamp.headCodeBitLow} == $past(headSelect))
    else $error("head code does not follow selection");
  a_write_mode_level: assert property (preamp.writeSelect |-> $past(writeRequest))
    else $error("write mode without write request");
  a_fault_forward: assert property ((unsafeSync && !preamp.chipEnableN) |=> writeFault)
    else $error("unsafe not forwarded as write fault");
  a_index_out: assert property ($rose(indexSync) |=> !indexPulseN)
    else $error("index not buffered out");
  a_lock_after_speed: assert property ($rose(motor.lockRelease) |-> $past(atSpeed))
    else $error("lock released before at speed");
  a_accel_free: assert property ((state == ST_ACCEL) |->
      !motor.stopMotor && !motor.normalRegulation)
    else $error("acceleration not unregulated");
  a_reg_on_band: assert property (s_band_hit |=> motor.normalRegulation)
    else $error("regulation not enabled in speed band");
  a_shutdown_speed: assert property (s_running_bad |=> motor.stopMotor ##1 motor.stopMotor)
    else $error("no shutdown on bad speed");
  a_stop_brakes: assert property (motor.stopMotor |->
      motor.brakeRelay && motor.phaseDrive == 3'h0 && !motor.lockRelease)
    else $error("stop without brake or with drive");
  a_comm_onehot: assert property ($onehot0(motor.phaseDrive))
    else $error("more than one phase driven");

endmodule
`default_nettype wire

// file: tb/shs_motor_model.sv
// Spindle motor model: index sensor, Hall levels and the two references.
// Assumes core_clk is the supervisor clock; index period set by the bench.
`timescale 1ns/1ps
`default_nettype none
module shs_motor_model (
  // Clock and control
  input wire logic core_clk,
  input wire logic spin,
  input wire logic [15:0] period,
  input wire logic [2:0] hallSet,
  // Sensor and reference outputs
  output logic [2:0] hallRaw,
  output logic indexRaw,
  output logic refCheck,
  output logic refRegulate
);
  logic [15:0] revCount;
  logic [9:0] regCount;
  initial begin
    revCount = 16'h0000;
    regCount = 10'h000;
    indexRaw = 1'b0;
    refCheck = 1'b0;
    refRegulate = 1'b0;
  end
  // Halls follow the bench; rotor position is not modelled
  assign hallRaw = hallSet;
  // Off-edge updates keep the sensor async to the sampling edge
  always @(posedge core_clk) begin
    #5;
    refCheck <= ~refCheck;
    regCount <= regCount + 10'h001;
    if (regCount == 10'h3FF) refRegulate <= ~refRegulate;
    if (!spin) begin
      revCount <= 16'h0000; // Lost index: no pulses at all
      indexRaw <= 1'b0;
    end else begin
      revCount <= (revCount == period - 16'h0001) ? 16'h0000 : revCount + 16'h0001;
      indexRaw <= (revCount < 16'h0003); // 3-cycle pulse
    end
  end
endmodule
`default_nettype wire

// file: tb/shs_supervisor_tb.sv
// Bench for the spindle and head supervisor, with the motor model.
// Assumes shortened index window 3000..3140 and 3070-cycle revolutions.
`timescale 1ns/1ps
`default_nettype none
module shs_supervisor_tb import shs_pkg::*; ;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic spin = 1'b0;
  logic [2:0] hallSet = 3'h0;
  logic [2:0] hallRaw;
  logic indexRaw, refCheck, refRegulate;
  logic unsafeFault = 1'b0;
  logic driveSelect = 1'b0;
  logic [1:0] headSelect = 2'h0;
  logic writeRequest = 1'b0;
  logic stopRequest = 1'b0;
  shs_preamp_t preamp;
  shs_motor_t motor;
  logic indexPulseN, writeFault, atSpeed, counterNotReady;
  int num_errors = 0;
  int tests_run = 0;

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  shs_motor_model i_model (.core_clk(core_clk), .spin(spin), .period(16'h0BFE),
    .hallSet(hallSet), .hallRaw(hallRaw), .indexRaw(indexRaw), .refCheck(refCheck),
    .refRegulate(refRegulate));

  shs_supervisor #(.IDX_MIN(3000), .IDX_MAX(3140)) i_dut (.core_clk(core_clk),
    .rst_n(rst_n), .hallRaw(hallRaw), .indexRaw(indexRaw), .refCheck(refCheck),
    .refRegulate(refRegulate), .unsafeFault(unsafeFault), .driveSelect(driveSelect),
    .headSelect(headSelect), .writeRequest(writeRequest), .stopRequest(stopRequest),
    .preamp(preamp), .motor(motor), .indexPulseN(indexPulseN), .writeFault(writeFault),
    .atSpeed(atSpeed), .counterNotReady(counterNotReady));

  // Inputs change and outputs are read 10 ns after each edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Level picked by number; struct members cannot be passed by reference
  function automatic logic pick(input int which);
    case (which)
      0: pick = indexRaw;
      1: pick = motor.normalRegulation;
      2: pick = motor.lockRelease;
      default: pick = motor.stopMotor;
    endcase
  endfunction

  // Bounded wait on a condition sampled once a cycle
  task automatic wait_for(input int which, input int bound, input string msg);
    int i;
    for (i = 0; i < bound && pick(which) !== 1'b1; i++) tick(1);
    if (pick(which) !== 1'b1) begin
      check(8'h00, 8'h01, msg);
      close_out();
    end
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    tick(8);
    check(motor, 8'h00, "motor after reset");
    check(preamp, 8'h08, "preamp after reset");
    check({indexPulseN, counterNotReady}, 8'h03, "status after reset");
    rst_n = 1'b1;
  endtask

  // Every Hall code, unregulated drive; disabled preamp gives no fault
  task automatic t_commute();
    int h;
    driveSelect = 1'b1;
    unsafeFault = 1'b1;
    for (h = 0; h < 8; h++) begin
      hallSet = 3'(h);
      tick(5);
      check(motor.phaseDrive, COMM_TABLE[h], "commutation");
    end
    check({preamp.chipEnableN, writeFault}, 8'h02, "disabled preamp");
    unsafeFault = 1'b0;
    hallSet = 3'h1;
  endtask

  // Index buffered out after exactly three edges
  task automatic t_index();
    spin = 1'b1;
    wait_for(0, 4000, "no index");
    tick(2);
    check(indexPulseN, 8'h01, "index too early");
    tick(1);
    check(indexPulseN, 8'h00, "index out");
  endtask

  // Regulation on speed window, lock only once at speed
  task automatic t_startup();
    wait_for(1, 8000, "no regulation");
    check({motor.lockRelease, motor.stopMotor}, 8'h00, "lock early");
    wait_for(2, 8000, "no lock release");
    check({atSpeed, counterNotReady}, 8'h02, "lock without speed");
  endtask

  // Head code, mode and both fault paths while running
  task automatic t_preamp();
    int h;
    writeRequest = 1'b1;
    for (h = 0; h < 4; h++) begin
      headSelect = 2'(h);
      tick(2);
      check(preamp, 8'(4'h4 | h), "head and write");
    end
    unsafeFault = 1'b1;
    tick(4);
    check({writeFault, preamp.writeSelect}, 8'h02, "write unsafe");
    unsafeFault = 1'b0;
    writeRequest = 1'b0;
    tick(4);
    check({writeFault, preamp.writeSelect}, 8'h00, "read mode");
    unsafeFault = 1'b1;
    tick(4);
    check(writeFault, 8'h01, "read unsafe");
    unsafeFault = 1'b0;
  endtask

  // Hall edges outrun the 360 Hz reference, so regulated drive is withheld
  task automatic t_regulate();
    int n;
    for (n = 0; n < 16; n++) begin
      hallSet = 3'h2;
      tick(2);
      hallSet = 3'h1;
      tick(2);
    end
    tick(4);
    check(motor.phaseDrive, 8'h00, "drive while leading");
  endtask

  // Lost index: shutdown with brake and no drive
  task automatic t_speed_loss();
    spin = 1'b0;
    wait_for(3, 10000, "no shutdown");
    tick(1);
    check(motor, 8'h0C, "brake and no drive");
    check({counterNotReady, atSpeed}, 8'h02, "not ready");
  endtask

  // Stop request during acceleration
  task automatic t_stop_request();
    do_reset();
    tick(4);
    stopRequest = 1'b1;
    tick(3);
    check({motor.stopMotor, motor.brakeRelay}, 8'h03, "stop request");
  endtask

  initial begin
    #10;
    do_reset();
    t_commute();
    t_index();
    t_startup();
    t_preamp();
    t_regulate();
    t_speed_loss();
    t_stop_request();
    close_out();
  end
endmodule
`default_nettype wire
